// ===== design/pesc_pkg.sv
// Constants and types shared by the program/erase suspend controller
package pesc_pkg;

   // ==========================================================
   // Link framing
   localparam logic [7:0] SUSPEND_OPCODE = 8'hB0;
   localparam int OPCODE_BITS = 8;

   // ==========================================================
   // Array geometry
   localparam int FLASH_ADDR_W = 19;
   localparam int SECTOR_LSB = 16;
   localparam int PAGE_LSB = 8;

   // ==========================================================
   // Timing
   localparam int SYS_CLK_PERIOD_NS = 20;
   localparam int SUSPEND_LATENCY_NS = 10000;
   localparam int SUSPEND_LATENCY_RAW = SUSPEND_LATENCY_NS / SYS_CLK_PERIOD_NS;
   localparam int SUSPEND_LATENCY_CYC = (SUSPEND_LATENCY_RAW < 1) ? 1 : SUSPEND_LATENCY_RAW;

   // ==========================================================
   // Data values
   localparam logic [7:0] UNDEF_READ_DATA = 8'hFF;

   // ==========================================================
   // Kind of operation the engine is running
   typedef enum logic [1:0] {
      PESC_OP_PROG_BUF1,
      PESC_OP_PROG_BUF2,
      PESC_OP_ERASE_PAGE,
      PESC_OP_ERASE_SECTOR
   } pesc_op_kind_t;

   // ==========================================================
   // Command classes from the opcode decoder
   typedef enum logic [4:0] {
      PESC_CMD_READ_ARRAY,
      PESC_CMD_READ_BUF1,
      PESC_CMD_READ_BUF2,
      PESC_CMD_BUF1_WRITE,
      PESC_CMD_BUF2_WRITE,
      PESC_CMD_BUF1_PROG_ERASE,
      PESC_CMD_BUF2_PROG_ERASE,
      PESC_CMD_BUF1_PROG_NOERASE,
      PESC_CMD_BUF2_PROG_NOERASE,
      PESC_CMD_MEM_PROG_BUF1_ERASE,
      PESC_CMD_MEM_PROG_BUF2_ERASE,
      PESC_CMD_MEM_PROG_BUF1_NOERASE,
      PESC_CMD_AUTO_REWRITE_BUF1,
      PESC_CMD_AUTO_REWRITE_BUF2,
      PESC_CMD_RMW_BUF1,
      PESC_CMD_RMW_BUF2,
      PESC_CMD_PAGE_ERASE,
      PESC_CMD_BLOCK_ERASE,
      PESC_CMD_SECTOR_ERASE,
      PESC_CMD_CHIP_ERASE,
      PESC_CMD_MEM_TO_BUF1,
      PESC_CMD_MEM_TO_BUF2,
      PESC_CMD_OTHER_ALLOWED,
      PESC_CMD_OTHER_FORBIDDEN
   } pesc_cmd_t;

endpackage

// ===== design/pesc_spi_rx.sv
// Link-side opcode capture running on the serial clock
`timescale 1ns/1ps
module pesc_spi_rx
   import pesc_pkg::*;
(
   input wire logic spi_clk_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_mosi_i,
   input wire logic link_rst_i,
   output logic [7:0] opcode_o,
   output logic opcode_tgl_o
);

   // ==========================================================
   // Bit counter, cleared by the frame's own select
   logic [3:0] bit_cnt_q;

   always_ff @(posedge spi_clk_i or posedge spi_cs_n_i) begin
      if (spi_cs_n_i) begin
         bit_cnt_q <= 4'h0;
      end else if (bit_cnt_q != 4'(OPCODE_BITS)) begin
         bit_cnt_q <= bit_cnt_q + 4'h1;
      end
   end

   // ==========================================================
   // Shift state
   typedef struct packed {
      logic [6:0] shift;
      logic [7:0] opcode;
      logic tgl;
   } pesc_rx_state_t;

   pesc_rx_state_t s_q;
   pesc_rx_state_t s_d;

   always_comb begin
      s_d = s_q;
      if (bit_cnt_q < 4'(OPCODE_BITS - 1)) begin
         s_d.shift = {s_q.shift[5:0], spi_mosi_i};
      end
      // Later bits are ignored
      if (bit_cnt_q == 4'(OPCODE_BITS - 1)) begin
         s_d.opcode = {s_q.shift, spi_mosi_i};
         s_d.tgl = ~s_q.tgl;
      end
   end

   always_ff @(posedge spi_clk_i or posedge link_rst_i) begin
      if (link_rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign opcode_o = s_q.opcode;
   assign opcode_tgl_o = s_q.tgl;

endmodule

// ===== design/pesc_cmd_gate.sv
// Command permission table for the suspend states
`timescale 1ns/1ps
module pesc_cmd_gate
   import pesc_pkg::*;
(
   input wire pesc_cmd_t cmd_class_i,
   input wire logic ps1_i,
   input wire logic ps2_i,
   input wire logic es_i,
   output logic allowed_o
);

   logic any_susp;
   logic any_prog_susp;

   assign any_susp = ps1_i | ps2_i | es_i;
   assign any_prog_susp = ps1_i | ps2_i;

   // ==========================================================
   // Permission lookup
   always_comb begin
      case (cmd_class_i)
         PESC_CMD_READ_ARRAY,
         PESC_CMD_READ_BUF1,
         PESC_CMD_READ_BUF2,
         PESC_CMD_OTHER_ALLOWED: begin
            allowed_o = 1'b1;
         end
         PESC_CMD_BUF1_WRITE,
         PESC_CMD_MEM_TO_BUF1: begin
            allowed_o = ~ps1_i;
         end
         PESC_CMD_BUF2_WRITE,
         PESC_CMD_MEM_TO_BUF2: begin
            allowed_o = ~ps2_i;
         end
         PESC_CMD_BUF1_PROG_NOERASE,
         PESC_CMD_BUF2_PROG_NOERASE: begin
            allowed_o = ~any_prog_susp;
         end
         PESC_CMD_MEM_PROG_BUF1_NOERASE: begin
            allowed_o = ~any_prog_susp;
         end
         PESC_CMD_BUF1_PROG_ERASE,
         PESC_CMD_BUF2_PROG_ERASE,
         PESC_CMD_MEM_PROG_BUF1_ERASE,
         PESC_CMD_MEM_PROG_BUF2_ERASE,
         PESC_CMD_PAGE_ERASE,
         PESC_CMD_BLOCK_ERASE,
         PESC_CMD_SECTOR_ERASE,
         PESC_CMD_CHIP_ERASE: begin
            allowed_o = ~any_susp;
         end
         PESC_CMD_AUTO_REWRITE_BUF1,
         PESC_CMD_AUTO_REWRITE_BUF2,
         PESC_CMD_RMW_BUF1,
         PESC_CMD_RMW_BUF2: begin
            allowed_o = ~any_susp;
         end
         default: begin
            allowed_o = ~any_susp;
         end
      endcase
   end

endmodule

// ===== design/pesc_suspend_ctrl.sv
// Program/erase suspend controller of a serial flash
// What this block does
// - Opcode B0h clocked in by the host is the suspend command.
// - Suspend has no address; any bits after the opcode are ignored.
// - On select release after suspend, the running operation halts within the latency.
// - Suspension sets buffer one, buffer two or erase suspended flag to one.
// - Once suspended, ready/busy reports ready for new operations.
// - Suspension covers one 64 kB sector; other sectors stay usable.
// - Reads of a suspended sector return undefined data.
// - Continuous reads give undefined data while the address sits in a suspended sector.
// - A program into an erase-suspended sector is aborted.
// - While erase-suspended, a program to another sector is accepted and suspendable.
// - Combined suspend holds erase flag and program flag both at one.
// - Reset during sector erase suspend aborts it; whole sector becomes undefined.
// - Reset during page suspend aborts it; only that page becomes undefined.
// - Array read and both buffer reads are always accepted while suspended.
// - Buffer program without erase only allowed during erase suspend.
// - Program with erase and all erases are refused in any suspend.
// - Memory program through buffer one without erase only during erase suspend.
// - Auto page rewrite and read-modify-write are refused in any suspend.
`timescale 1ns/1ps
module pesc_suspend_ctrl
   import pesc_pkg::*;
#(
   parameter int ADDR_W = FLASH_ADDR_W,
   parameter int SUSP_CYC = SUSPEND_LATENCY_CYC
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic spi_clk_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_mosi_i,
   input wire logic reset_pin_n_i,
   input wire logic soft_reset_i,
   input wire logic resume_i,
   input wire logic op_busy_i,
   input wire pesc_op_kind_t op_kind_i,
   input wire logic [ADDR_W-1:0] op_addr_i,
   input wire logic cmd_valid_i,
   input wire pesc_cmd_t cmd_class_i,
   input wire logic [ADDR_W-1:0] cmd_addr_i,
   input wire logic rd_active_i,
   input wire logic [ADDR_W-1:0] rd_addr_i,
   input wire logic [7:0] rd_data_i,
   output logic halt_prog_o,
   output logic halt_erase_o,
   output logic buffer_one_program_suspended_flag_o,
   output logic buffer_two_program_suspended_flag_o,
   output logic erase_suspended_flag_o,
   output logic ready_o,
   output logic cmd_accept_o,
   output logic cmd_reject_o,
   output logic prog_abort_o,
   output logic susp_abort_o,
   output logic [7:0] rd_data_o,
   output logic rd_undefined_o,
   output logic erase_undef_valid_o,
   output logic [ADDR_W-1:0] erase_undef_addr_o,
   output logic erase_undef_whole_sector_o,
   output logic prog_undef_valid_o,
   output logic [ADDR_W-1:0] prog_undef_addr_o
);

   localparam int SEC_W = ADDR_W - SECTOR_LSB;
   localparam int PG_W = ADDR_W - PAGE_LSB;
   localparam int LAT_W = $clog2(SUSP_CYC + 1);
   localparam logic [LAT_W-1:0] LAT_LOAD = LAT_W'(SUSP_CYC - 1);

   // ==========================================================
   // Link side
   logic [7:0] link_opcode;
   logic link_opcode_tgl;

   pesc_spi_rx u_spi_rx (
      .spi_clk_i(spi_clk_i),
      .spi_cs_n_i(spi_cs_n_i),
      .spi_mosi_i(spi_mosi_i),
      .link_rst_i(rst_i),
      .opcode_o(link_opcode),
      .opcode_tgl_o(link_opcode_tgl)
   );

   // ==========================================================
   // State
   typedef enum logic {
      PESC_ST_IDLE,
      PESC_ST_HALTING
   } pesc_state_t;

   typedef struct packed {
      pesc_state_t st;
      logic [3:0] cs_sync;
      logic [1:0] tgl_sync;
      logic tgl_seen;
      logic [1:0] pin_sync;
      logic pin_prev;
      logic [LAT_W-1:0] lat_cnt;
      pesc_op_kind_t halt_kind;
      logic [ADDR_W-1:0] halt_addr;
      logic ps1;
      logic ps2;
      logic es;
      logic es_page_level;
      logic [SEC_W-1:0] es_sector;
      logic [PG_W-1:0] es_page;
      logic [SEC_W-1:0] ps_sector;
      logic [PG_W-1:0] ps_page;
      logic halt_prog;
      logic halt_erase;
      logic ready;
      logic cmd_accept;
      logic cmd_reject;
      logic prog_abort;
      logic susp_abort;
      logic [7:0] rd_data;
      logic rd_undef;
      logic erase_undef_valid;
      logic [ADDR_W-1:0] erase_undef_addr;
      logic erase_undef_sector;
      logic prog_undef_valid;
      logic [ADDR_W-1:0] prog_undef_addr;
   } pesc_ctrl_state_t;

   pesc_ctrl_state_t s_q;
   pesc_ctrl_state_t s_d;

   // ==========================================================
   // Command permission
   logic gate_allowed;

   pesc_cmd_gate u_cmd_gate (
      .cmd_class_i(cmd_class_i),
      .ps1_i(s_q.ps1),
      .ps2_i(s_q.ps2),
      .es_i(s_q.es),
      .allowed_o(gate_allowed)
   );

   // ==========================================================
   // Decoded events
   logic frame_end;
   logic opcode_new;
   logic suspend_cmd;
   logic reset_evt;
   logic pin_held;
   logic cmd_is_prog;
   logic cmd_in_es_sector;
   logic rd_in_susp;
   logic [SEC_W-1:0] rd_sector;
   logic [SEC_W-1:0] cmd_sector;

   // Late edge of select so the opcode toggle has settled
   assign frame_end = s_q.cs_sync[2] & ~s_q.cs_sync[3];
   assign opcode_new = s_q.tgl_sync[1] ^ s_q.tgl_seen;
   assign suspend_cmd = frame_end & opcode_new & (link_opcode == SUSPEND_OPCODE);
   assign pin_held = ~s_q.pin_sync[1];
   assign reset_evt = soft_reset_i | (pin_held & ~s_q.pin_prev);

   assign rd_sector = rd_addr_i[ADDR_W-1:SECTOR_LSB];
   assign cmd_sector = cmd_addr_i[ADDR_W-1:SECTOR_LSB];

   // Sector compare for reads
   assign rd_in_susp = (s_q.es & (rd_sector == s_q.es_sector)) |
      ((s_q.ps1 | s_q.ps2) & (rd_sector == s_q.ps_sector));

   always_comb begin
      case (cmd_class_i)
         PESC_CMD_BUF1_PROG_ERASE,
         PESC_CMD_BUF2_PROG_ERASE,
         PESC_CMD_BUF1_PROG_NOERASE,
         PESC_CMD_BUF2_PROG_NOERASE,
         PESC_CMD_MEM_PROG_BUF1_ERASE,
         PESC_CMD_MEM_PROG_BUF2_ERASE,
         PESC_CMD_MEM_PROG_BUF1_NOERASE: begin
            cmd_is_prog = 1'b1;
         end
         default: begin
            cmd_is_prog = 1'b0;
         end
      endcase
   end

   assign cmd_in_es_sector = s_q.es & (cmd_sector == s_q.es_sector);

   // ==========================================================
   // Next state
   always_comb begin
      s_d = s_q;
      s_d.cs_sync = {s_q.cs_sync[2:0], spi_cs_n_i};
      s_d.tgl_sync = {s_q.tgl_sync[0], link_opcode_tgl};
      s_d.pin_sync = {s_q.pin_sync[0], reset_pin_n_i};
      s_d.pin_prev = pin_held;
      s_d.cmd_accept = 1'b0;
      s_d.cmd_reject = 1'b0;
      s_d.prog_abort = 1'b0;
      s_d.susp_abort = 1'b0;
      s_d.erase_undef_valid = 1'b0;
      s_d.prog_undef_valid = 1'b0;

      if (frame_end) begin
         s_d.tgl_seen = s_q.tgl_sync[1];
      end

      // Suspend sequencing
      case (s_q.st)
         PESC_ST_IDLE: begin
            // Nothing running means nothing to suspend
            if (suspend_cmd && op_busy_i) begin
               s_d.st = PESC_ST_HALTING;
               s_d.lat_cnt = LAT_LOAD;
               s_d.halt_kind = op_kind_i;
               s_d.halt_addr = op_addr_i;
               if (op_kind_i == PESC_OP_PROG_BUF1 || op_kind_i == PESC_OP_PROG_BUF2) begin
                  s_d.halt_prog = 1'b1;
               end else begin
                  s_d.halt_erase = 1'b1;
               end
            end else if (resume_i) begin
               // Program resumes before erase
               if (s_q.ps1 || s_q.ps2) begin
                  s_d.ps1 = 1'b0;
                  s_d.ps2 = 1'b0;
                  s_d.halt_prog = 1'b0;
               end else if (s_q.es) begin
                  s_d.es = 1'b0;
                  s_d.halt_erase = 1'b0;
               end
            end
         end
         PESC_ST_HALTING: begin
            if (s_q.lat_cnt == '0) begin
               s_d.st = PESC_ST_IDLE;
               case (s_q.halt_kind)
                  PESC_OP_PROG_BUF1: begin
                     s_d.ps1 = 1'b1;
                  end
                  PESC_OP_PROG_BUF2: begin
                     s_d.ps2 = 1'b1;
                  end
                  default: begin
                     // Program flags left as they are
                     s_d.es = 1'b1;
                     s_d.es_page_level = (s_q.halt_kind == PESC_OP_ERASE_PAGE);
                     s_d.es_sector = s_q.halt_addr[ADDR_W-1:SECTOR_LSB];
                     s_d.es_page = s_q.halt_addr[ADDR_W-1:PAGE_LSB];
                  end
               endcase
               if (s_q.halt_kind == PESC_OP_PROG_BUF1 || s_q.halt_kind == PESC_OP_PROG_BUF2) begin
                  // Erase flag stays up beside the program flag
                  s_d.ps_sector = s_q.halt_addr[ADDR_W-1:SECTOR_LSB];
                  s_d.ps_page = s_q.halt_addr[ADDR_W-1:PAGE_LSB];
               end
            end else begin
               s_d.lat_cnt = s_q.lat_cnt - LAT_W'(1);
            end
         end
         default: begin
            s_d.st = PESC_ST_IDLE;
         end
      endcase

      // Command screening
      if (cmd_valid_i) begin
         if (cmd_is_prog && cmd_in_es_sector) begin
            s_d.prog_abort = 1'b1;
            s_d.cmd_reject = 1'b1;
         end else if (gate_allowed) begin
            s_d.cmd_accept = 1'b1;
         end else begin
            s_d.cmd_reject = 1'b1;
         end
      end

      // Reset aborts suspended work
      if (reset_evt || pin_held) begin
         if (reset_evt && s_q.es) begin
            s_d.erase_undef_valid = 1'b1;
            s_d.erase_undef_sector = ~s_q.es_page_level;
            if (s_q.es_page_level) begin
               s_d.erase_undef_addr = {s_q.es_page, PAGE_LSB'(0)};
            end else begin
               s_d.erase_undef_addr = {s_q.es_sector, SECTOR_LSB'(0)};
            end
         end
         if (reset_evt && (s_q.ps1 || s_q.ps2)) begin
            s_d.prog_undef_valid = 1'b1;
            s_d.prog_undef_addr = {s_q.ps_page, PAGE_LSB'(0)};
         end
         s_d.susp_abort = reset_evt & (s_q.es | s_q.ps1 | s_q.ps2 | (s_q.st == PESC_ST_HALTING));
         s_d.st = PESC_ST_IDLE;
         s_d.ps1 = 1'b0;
         s_d.ps2 = 1'b0;
         s_d.es = 1'b0;
         s_d.halt_prog = 1'b0;
         s_d.halt_erase = 1'b0;
      end

      // Ready once no operation runs and no halt is pending
      s_d.ready = (s_d.st == PESC_ST_IDLE) & ~op_busy_i;

      // Array read data path
      if (rd_active_i && rd_in_susp) begin
         s_d.rd_data = UNDEF_READ_DATA;
         s_d.rd_undef = 1'b1;
      end else begin
         s_d.rd_data = rd_data_i;
         s_d.rd_undef = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         s_q <= '0;
         s_q.cs_sync <= 4'hF;
         s_q.pin_sync <= 2'h3;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // Outputs
   assign halt_prog_o = s_q.halt_prog;
   assign halt_erase_o = s_q.halt_erase;
   assign buffer_one_program_suspended_flag_o = s_q.ps1;
   assign buffer_two_program_suspended_flag_o = s_q.ps2;
   assign erase_suspended_flag_o = s_q.es;
   assign ready_o = s_q.ready;
   assign cmd_accept_o = s_q.cmd_accept;
   assign cmd_reject_o = s_q.cmd_reject;
   assign prog_abort_o = s_q.prog_abort;
   assign susp_abort_o = s_q.susp_abort;
   assign rd_data_o = s_q.rd_data;
   assign rd_undefined_o = s_q.rd_undef;
   assign erase_undef_valid_o = s_q.erase_undef_valid;
   assign erase_undef_addr_o = s_q.erase_undef_addr;
   assign erase_undef_whole_sector_o = s_q.erase_undef_sector;
   assign prog_undef_valid_o = s_q.prog_undef_valid;
   assign prog_undef_addr_o = s_q.prog_undef_addr;

endmodule

// ===== testbench/pesc_suspend_ctrl_properties.sv
// Port-level checks for the program/erase suspend controller
`timescale 1ns/1ps
module pesc_suspend_ctrl_checker
   import pesc_pkg::*;
#(
   parameter int SUSP_CYC = 4
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic reset_pin_n_i,
   input wire logic soft_reset_i,
   input wire logic resume_i,
   input wire logic op_busy_i,
   input wire logic cmd_valid_i,
   input wire pesc_cmd_t cmd_class_i,
   input wire logic rd_active_i,
   input wire logic [7:0] rd_data_i,
   input wire logic halt_prog_o,
   input wire logic halt_erase_o,
   input wire logic buffer_one_program_suspended_flag_o,
   input wire logic buffer_two_program_suspended_flag_o,
   input wire logic erase_suspended_flag_o,
   input wire logic ready_o,
   input wire logic cmd_accept_o,
   input wire logic cmd_reject_o,
   input wire logic [7:0] rd_data_o,
   input wire logic rd_undefined_o,
   input wire logic erase_undef_valid_o
);
   wire f_one = buffer_one_program_suspended_flag_o;
   wire f_two = buffer_two_program_suspended_flag_o;
   wire f_er = erase_suspended_flag_o;
   wire any_f = f_one | f_two | f_er;
   logic [2:0] pin_cnt_q;
   always_ff @(posedge sys_clk_i) begin
      if (!reset_pin_n_i) pin_cnt_q <= 3'h0;
      else if (pin_cnt_q != 3'h7) pin_cnt_q <= pin_cnt_q + 3'h1;
   end
   // ==========================================================
   // Assertions
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   erase_latency_a: assert property ($rose(halt_erase_o) |-> ##SUSP_CYC $rose(f_er))
      else $error("erase flag not set at end of latency");
   prog_latency_a: assert property ($rose(halt_prog_o) |-> ##SUSP_CYC ($rose(f_one) || $rose(f_two)))
      else $error("program flag not set at end of latency");
   ready_after_a: assert property (($rose(f_one) || $rose(f_two) || $rose(f_er)) && !op_busy_i
      |=> ready_o)
      else $error("ready missing after suspension");
   reads_ok_a: assert property (cmd_valid_i && cmd_class_i inside {PESC_CMD_READ_ARRAY,
      PESC_CMD_READ_BUF1, PESC_CMD_READ_BUF2} |=> cmd_accept_o && !cmd_reject_o)
      else $error("read command refused");
   erase_forbid_a: assert property (cmd_valid_i && any_f && cmd_class_i inside {
      PESC_CMD_BUF1_PROG_ERASE, PESC_CMD_BUF2_PROG_ERASE, PESC_CMD_MEM_PROG_BUF1_ERASE,
      PESC_CMD_MEM_PROG_BUF2_ERASE, PESC_CMD_AUTO_REWRITE_BUF1, PESC_CMD_AUTO_REWRITE_BUF2,
      PESC_CMD_RMW_BUF1, PESC_CMD_RMW_BUF2, PESC_CMD_PAGE_ERASE, PESC_CMD_BLOCK_ERASE,
      PESC_CMD_SECTOR_ERASE, PESC_CMD_CHIP_ERASE} |=> cmd_reject_o && !cmd_accept_o)
      else $error("forbidden command accepted while suspended");
   prog_forbid_a: assert property (cmd_valid_i && (f_one || f_two) && cmd_class_i inside {
      PESC_CMD_BUF1_PROG_NOERASE, PESC_CMD_BUF2_PROG_NOERASE, PESC_CMD_MEM_PROG_BUF1_NOERASE}
      |=> cmd_reject_o)
      else $error("program accepted during program suspend");
   undef_data_a: assert property (rd_undefined_o |-> rd_data_o == UNDEF_READ_DATA)
      else $error("undefined read without undefined data");
   clean_read_a: assert property (rd_active_i && !any_f
      |=> !rd_undefined_o && rd_data_o == $past(rd_data_i))
      else $error("read of unsuspended array altered");
   flag_hold_a: assert property (!resume_i && !soft_reset_i && reset_pin_n_i && pin_cnt_q > 3'h4
      |=> !$fell(f_one) && !$fell(f_two) && !$fell(f_er))
      else $error("suspend flag dropped without resume or reset");
   soft_undef_a: assert property (soft_reset_i && f_er |=> erase_undef_valid_o && !f_er)
      else $error("soft reset left erase suspend in place");
   cover property (f_one && f_er);
   cover property ($rose(erase_undef_valid_o));
   cover property (rd_undefined_o);
endmodule

bind pesc_suspend_ctrl pesc_suspend_ctrl_checker #(.SUSP_CYC(SUSP_CYC)) chk_u (.*);

// ===== testbench/pesc_host_model.sv
// Host serial link driver for the suspend controller bench
`timescale 1ns/1ps
module pesc_host_model (
   output logic spi_clk_o,
   output logic spi_cs_n_o,
   output logic spi_mosi_o
);
   initial {spi_clk_o, spi_cs_n_o, spi_mosi_o} = 3'b010;
   // ==========================================================
   // Frame of n bits, MSB first, clock still between frames
   task automatic send(input logic [15:0] bits, input int n);
      #100 spi_cs_n_o = 1'b0;
      #31;
      for (int i = 15; i > 15 - n; i--) begin
         spi_mosi_o = bits[i];
         #62.5 spi_clk_o = 1'b1;
         #62.5 spi_clk_o = 1'b0;
      end
      #31 spi_cs_n_o = 1'b1;
      spi_mosi_o = ~spi_mosi_o;
   endtask
endmodule

// ===== testbench/pesc_suspend_ctrl_bench.sv
// Self-checking bench for the program/erase suspend controller
`timescale 1ns/1ps
module pesc_suspend_ctrl_bench;
   import pesc_pkg::*;
   localparam int SC = 4;
   logic sys_clk_i, rst_i, reset_pin_n_i, soft_reset_i, resume_i, op_busy_i;
   logic cmd_valid_i, rd_active_i, spi_clk_i, spi_cs_n_i, spi_mosi_i;
   pesc_op_kind_t op_kind_i;
   pesc_cmd_t cmd_class_i;
   logic [18:0] op_addr_i, cmd_addr_i, rd_addr_i, erase_undef_addr_o, prog_undef_addr_o;
   logic [7:0] rd_data_i, rd_data_o;
   logic halt_prog_o, halt_erase_o, f_one, f_two, f_er, ready_o, cmd_accept_o, cmd_reject_o;
   logic prog_abort_o, susp_abort_o, rd_undefined_o, erase_undef_valid_o;
   logic erase_undef_whole_sector_o, prog_undef_valid_o;
   int errors = 0, n_compared = 0, cycles = 0;
   pesc_cmd_t cl [18] = '{PESC_CMD_READ_ARRAY, PESC_CMD_READ_BUF1, PESC_CMD_READ_BUF2,
      PESC_CMD_BUF1_PROG_NOERASE, PESC_CMD_BUF2_PROG_NOERASE, PESC_CMD_MEM_PROG_BUF1_NOERASE,
      PESC_CMD_BUF1_PROG_ERASE, PESC_CMD_BUF2_PROG_ERASE, PESC_CMD_MEM_PROG_BUF1_ERASE,
      PESC_CMD_MEM_PROG_BUF2_ERASE, PESC_CMD_AUTO_REWRITE_BUF1, PESC_CMD_AUTO_REWRITE_BUF2,
      PESC_CMD_RMW_BUF1, PESC_CMD_RMW_BUF2, PESC_CMD_PAGE_ERASE, PESC_CMD_BLOCK_ERASE,
      PESC_CMD_SECTOR_ERASE, PESC_CMD_CHIP_ERASE};
   pesc_host_model host_u (.spi_clk_o(spi_clk_i), .spi_cs_n_o(spi_cs_n_i), .spi_mosi_o(spi_mosi_i));
   pesc_suspend_ctrl #(.SUSP_CYC(SC)) dut_u (.*, .buffer_one_program_suspended_flag_o(f_one),
      .buffer_two_program_suspended_flag_o(f_two), .erase_suspended_flag_o(f_er));
   // ==========================================================
   // Clock, timeout and reporting
   initial begin
      sys_clk_i = 1'b0;
      forever #10 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         $display("mismatch at %0t: timeout", $time);
         report_and_stop();
      end
   end
   task automatic report_and_stop;
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cmp_vec(input logic [18:0] got, input logic [18:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: %s got %h", $time, what, got);
      end
   endtask
   function automatic logic fl(input pesc_op_kind_t k);
      return k == PESC_OP_PROG_BUF1 ? f_one : k == PESC_OP_PROG_BUF2 ? f_two : f_er;
   endfunction
   // ==========================================================
   // Access tasks
   task automatic cmd(input pesc_cmd_t c, input logic [18:0] a, input logic acc);
      @(posedge sys_clk_i);
      cmd_valid_i <= 1'b1;
      cmd_class_i <= c;
      cmd_addr_i <= a;
      @(posedge sys_clk_i);
      cmd_valid_i <= 1'b0;
      @(negedge sys_clk_i);
      cmp_vec({cmd_accept_o, cmd_reject_o}, {acc, !acc}, c.name());
   endtask
   task automatic rd(input logic [18:0] a, input logic undef);
      @(posedge sys_clk_i);
      rd_active_i <= 1'b1;
      rd_addr_i <= a;
      @(posedge sys_clk_i);
      rd_active_i <= 1'b0;
      @(negedge sys_clk_i);
      cmp_vec({rd_undefined_o, rd_data_o}, undef ? 9'h1FF : 9'h05A, "read");
   endtask
   task automatic suspend(input pesc_op_kind_t k, input logic [18:0] a);
      logic prog = k inside {PESC_OP_PROG_BUF1, PESC_OP_PROG_BUF2};
      @(posedge sys_clk_i);
      op_kind_i <= k;
      op_addr_i <= a;
      op_busy_i <= 1'b1;
      host_u.send(16'hB0C3, 16);
      for (int i = 0; i < 40; i++) begin
         @(negedge sys_clk_i);
         if (prog ? halt_prog_o : halt_erase_o) break;
      end
      cmp_vec(prog ? halt_prog_o : halt_erase_o, 1, "halt");
      @(posedge sys_clk_i);
      op_busy_i <= 1'b0;
      repeat (SC - 1) @(negedge sys_clk_i);
      cmp_vec(fl(k), 0, "flag early");
      @(negedge sys_clk_i);
      cmp_vec(fl(k), 1, "flag");
      @(negedge sys_clk_i);
      cmp_vec(ready_o, 1, "ready");
   endtask
   // ==========================================================
   // Tests
   initial begin
      {rst_i, reset_pin_n_i} = 2'b11;
      {soft_reset_i, resume_i, op_busy_i, cmd_valid_i, rd_active_i} = 5'h00;
      op_kind_i = PESC_OP_ERASE_SECTOR;
      cmd_class_i = PESC_CMD_OTHER_ALLOWED;
      {op_addr_i, cmd_addr_i, rd_addr_i} = 57'h0;
      rd_data_i = 8'h5A;
      repeat (16) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      @(negedge sys_clk_i);
      cmp_vec({f_one, f_two, f_er, ready_o}, 0, "reset state");
      host_u.send(16'hB000, 8);
      repeat (20) @(negedge sys_clk_i);
      cmp_vec({halt_prog_o, halt_erase_o, f_er, f_one}, 0, "idle suspend");
      $display("test idle_suspend done");
      @(posedge sys_clk_i);
      op_busy_i <= 1'b1;
      host_u.send(16'hB100, 8);
      host_u.send(16'hB000, 7);
      repeat (20) @(negedge sys_clk_i);
      cmp_vec({halt_prog_o, halt_erase_o}, 0, "other opcode");
      @(posedge sys_clk_i);
      op_busy_i <= 1'b0;
      rd(19'h2_0000, 1'b0);
      $display("test opcode_filter done");
      suspend(PESC_OP_ERASE_SECTOR, 19'h2_1234);
      rd(19'h2_FFFF, 1'b1);
      rd(19'h3_0000, 1'b0);
      for (int i = 0; i < 18; i++) cmd(cl[i], 19'h3_0100, i < 6);
      cmd(PESC_CMD_BUF1_PROG_NOERASE, 19'h2_0400, 1'b0);
      cmp_vec(prog_abort_o, 1, "program abort");
      $display("test erase_suspend done");
      suspend(PESC_OP_PROG_BUF1, 19'h3_0100);
      cmp_vec({f_one, f_er}, 2'b11, "combined flags");
      for (int i = 0; i < 18; i++) cmd(cl[i], 19'h4_0000, i < 3);
      @(posedge sys_clk_i);
      resume_i <= 1'b1;
      @(posedge sys_clk_i);
      resume_i <= 1'b0;
      @(negedge sys_clk_i);
      cmp_vec({f_one, f_er}, 2'b01, "after resume");
      @(posedge sys_clk_i);
      soft_reset_i <= 1'b1;
      @(posedge sys_clk_i);
      soft_reset_i <= 1'b0;
      @(negedge sys_clk_i);
      cmp_vec({erase_undef_valid_o, erase_undef_whole_sector_o, f_er, susp_abort_o}, 4'hD, "soft");
      cmp_vec(erase_undef_addr_o, 19'h2_0000, "sector base");
      $display("test combined_suspend done");
      suspend(PESC_OP_ERASE_PAGE, 19'h3_4567);
      suspend(PESC_OP_PROG_BUF2, 19'h5_0234);
      @(posedge sys_clk_i);
      reset_pin_n_i <= 1'b0;
      for (int i = 0; i < 10; i++) begin
         @(negedge sys_clk_i);
         if (erase_undef_valid_o) break;
      end
      cmp_vec({erase_undef_valid_o, erase_undef_whole_sector_o, prog_undef_valid_o, susp_abort_o},
         4'hB, "pin");
      cmp_vec(prog_undef_addr_o, 19'h5_0200, "prog page");
      cmp_vec(erase_undef_addr_o, 19'h3_4500, "page base");
      @(posedge sys_clk_i);
      reset_pin_n_i <= 1'b1;
      repeat (8) @(negedge sys_clk_i);
      cmp_vec({f_er, f_two}, 0, "flag after pin");
      $display("test page_reset done");
      report_and_stop();
   end
endmodule
